// *** hw/pmm_pkg.sv ***
// Purpose: constants and types for the program-memory map and flash access block
// Assumes: 25 MHz core clock, 16-bit program address, byte-wide memory
// Notes:   times are given in their own unit, cycle counts derived from the clock
//
// Contract
// - Flash is split into five erase blocks, the lowest two being 8 KB each and covering 0000 to 3FFF.
// - The other three blocks are 16 KB each covering 4000 to FFFF, chosen by the upper address bits.
// - With the boot ROM enabled and the external-fetch select high, fetches from FC00 to FFFF are answered by the boot ROM, not flash.
// - The boot ROM overlay can be switched off, making the top 1 KB of flash fetchable like any other.
// - The boot ROM is a separate 1 KB store of erase, program and verify code with one common entry address.
// - With the external-fetch select low, internal memory is disabled and all fetches go to external memory.
// - Flash is read and programmed a byte at a time, a byte program taking about 20 us.
// - A chip erase clears the whole internal program memory in one command.
// - A block erase clears one flash block and leaves the others untouched.
// - A block erase takes about 10 s and a full erase about 20 s.
// - A stored boot start value can point a user loader at any 256-byte boundary in the flash space.
// - At reset release a zero boot status value starts execution at 0000.
// - A nonzero boot status value starts execution at the stored boot start value times 256.
package pmm_pkg;
   localparam int          ADDR_W          = 16;
   localparam int          DATA_W          = 8;
   localparam int          CLK_HZ          = 25000000;
   localparam logic [15:0] BLK1_BASE       = 16'h2000;
   localparam logic [15:0] BLK2_BASE       = 16'h4000;
   localparam logic [15:0] FLASH_TOP       = 16'hFFFF;
   localparam logic [15:0] BOOT_ROM_BASE   = 16'hFC00;
   localparam int          BOOT_ROM_BYTES  = 1024;
   localparam logic [15:0] IAP_ENTRY_ADDR  = 16'hFF00;
   localparam logic [15:0] RESET_START     = 16'h0000;
   localparam logic [7:0]  START_LOW_BYTE  = 8'h00;
   localparam logic [7:0]  ERASED_BYTE     = 8'hFF;
   localparam logic [7:0]  STATUS_ZERO     = 8'h00;
   localparam int          PROG_TIME_NS    = 20000;
   localparam int          BLK_ERASE_S     = 10;
   localparam int          CHIP_ERASE_S    = 20;
   localparam int          PROG_CYCLES     = (PROG_TIME_NS * (CLK_HZ / 1000000)) / 1000;
   localparam longint      BLK_ERASE_CYC   = longint'(BLK_ERASE_S) * CLK_HZ;
   localparam longint      CHIP_ERASE_CYC  = longint'(CHIP_ERASE_S) * CLK_HZ;

   typedef enum logic [2:0] {
      PMM_OP_READ        = 3'h0,
      PMM_OP_PROGRAM     = 3'h1,
      PMM_OP_BLOCK_ERASE = 3'h2,
      PMM_OP_CHIP_ERASE  = 3'h3,
      PMM_OP_SET_STATUS  = 3'h4,
      PMM_OP_SET_VECTOR  = 3'h5,
      PMM_OP_CLEAR_BOOT  = 3'h6
   } pmm_op_type;

   typedef struct packed {
      pmm_op_type       op;
      logic [15:0]      addr;
      logic [7:0]       wdata;
   } pmm_cmd_type;

   typedef struct packed {
      logic             req;
      logic [15:0]      addr;
   } pmm_fetch_type;
endpackage

// *** hw/pmm_flash_map.sv ***
// Purpose: program-memory decode, boot ROM overlay, flash byte access and erase timing
// Assumes: external program memory answers combinationally within the request cycle
// Notes:   flash and boot settings are nonvolatile, so they are not cleared by rst
`timescale 1ns/1ps
`default_nettype none
module pmm_flash_map #(
   parameter int unsigned PROG_CYC    = pmm_pkg::PROG_CYCLES,
   parameter longint      BLK_ERS_CYC = pmm_pkg::BLK_ERASE_CYC,
   parameter longint      CHIP_ERS_CYC = pmm_pkg::CHIP_ERASE_CYC
) (
   input  wire logic                 mclk,
   input  wire logic                 rst,
   input  wire pmm_pkg::pmm_fetch_type fetch,
   output logic                      fetch_valid,
   output logic [7:0]                fetch_data,
   output logic                      fetch_from_rom,
   input  wire logic                 external_fetch_select_n,
   output logic                      ext_rd,
   output logic [15:0]               ext_addr,
   input  wire logic [7:0]           ext_data,
   input  wire logic                 boot_rom_off,
   input  wire logic                 boot_rom_on,
   output logic                      boot_rom_enabled,
   input  wire logic                 rom_load,
   input  wire logic [9:0]           rom_load_addr,
   input  wire logic [7:0]           rom_load_data,
   output logic [15:0]               iap_entry,
   input  wire logic                 cmd_valid,
   input  wire pmm_pkg::pmm_cmd_type cmd,
   output logic                      cmd_refused,
   output logic                      busy,
   output logic                      done,
   output logic [7:0]                rd_data,
   output logic [15:0]               start_addr,
   output logic                      start_valid
);
   import pmm_pkg::*;

   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_PROG  = 4'b0010,
      ST_BERS  = 4'b0100,
      ST_CERS  = 4'b1000
   } pmm_state_type;

   logic [7:0]    flash_mem [0:65535];
   logic [7:0]    rom_mem   [0:BOOT_ROM_BYTES-1];
   logic [7:0]    boot_status_reg;
   logic [7:0]    boot_vector_reg;
   pmm_state_type state_reg;
   logic [63:0]   timer_reg;
   logic [16:0]   sweep_reg;
   logic [15:0]   op_addr_reg;
   logic [7:0]    op_data_reg;
   logic [2:0]    op_block_reg;
   logic          rom_en_reg;
   logic          start_pend_reg;
   logic          timer_done;
   logic          sweep_done;
   logic          in_overlay;
   logic          write_cmd;

   // block number 0..4 from the address
   function automatic logic [2:0] block_of(input logic [15:0] a);
      if (a < BLK2_BASE) begin
         block_of = (a < BLK1_BASE) ? 3'h0 : 3'h1;
      end else begin
         block_of = 3'({1'b0, a[15:14]} + 3'h1);
      end
   endfunction

   // first address of the block holding a; a block erase sweeps only its own block
   function automatic logic [15:0] block_base(input logic [15:0] a);
      if (a < BLK2_BASE) begin
         block_base = {a[15:13], 13'h0};
      end else begin
         block_base = {a[15:14], 14'h0};
      end
   endfunction

   assign iap_entry        = IAP_ENTRY_ADDR;
   assign boot_rom_enabled = rom_en_reg;
   assign busy             = (state_reg != ST_IDLE);
   assign in_overlay       = rom_en_reg && (fetch.addr >= BOOT_ROM_BASE);
   assign ext_rd           = fetch.req && !external_fetch_select_n;
   assign ext_addr         = fetch.addr;
   assign write_cmd        = cmd.op != PMM_OP_READ;
   assign timer_done       = (timer_reg == 64'h0);
   assign sweep_done       = sweep_reg[16] ||
                             (state_reg == ST_BERS && block_of(sweep_reg[15:0]) != op_block_reg);

   // overlay flag; off wins over on when both pulse together
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rom_en_reg <= 1'b1;
      end else if (boot_rom_off) begin
         rom_en_reg <= 1'b0;
      end else if (boot_rom_on) begin
         rom_en_reg <= 1'b1;
      end
   end

   // factory load of the separate boot store
   always_ff @(posedge mclk) begin
      if (rom_load) begin
         rom_mem[rom_load_addr] <= rom_load_data;
      end
   end

   // instruction fetch, one cycle from request to data
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         fetch_valid    <= 1'b0;
         fetch_data     <= 8'h00;
         fetch_from_rom <= 1'b0;
      end else begin
         fetch_valid    <= fetch.req;
         fetch_from_rom <= fetch.req && external_fetch_select_n && in_overlay;
         if (fetch.req) begin
            if (!external_fetch_select_n) begin
               fetch_data <= ext_data;
            end else if (in_overlay) begin
               fetch_data <= rom_mem[fetch.addr[9:0]];
            end else begin
               fetch_data <= flash_mem[fetch.addr];
            end
         end
      end
   end

   // program / erase sequencer
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state_reg    <= ST_IDLE;
         timer_reg    <= 64'h0;
         sweep_reg    <= 17'h0;
         op_addr_reg  <= 16'h0;
         op_data_reg  <= 8'h00;
         op_block_reg <= 3'h0;
         cmd_refused  <= 1'b0;
         done         <= 1'b0;
         rd_data      <= 8'h00;
      end else begin
         cmd_refused <= 1'b0;
         done        <= 1'b0;
         case (state_reg)
            ST_IDLE: begin
               if (cmd_valid) begin
                  op_addr_reg  <= cmd.addr;
                  op_data_reg  <= cmd.wdata;
                  op_block_reg <= block_of(cmd.addr);
                  sweep_reg    <= (cmd.op == PMM_OP_BLOCK_ERASE) ? {1'b0, block_base(cmd.addr)} : 17'h0;
                  case (cmd.op)
                     PMM_OP_READ: begin
                        rd_data <= flash_mem[cmd.addr];
                        done    <= 1'b1;
                     end
                     PMM_OP_PROGRAM: begin
                        state_reg <= ST_PROG;
                        timer_reg <= 64'(PROG_CYC - 1);
                     end
                     PMM_OP_BLOCK_ERASE: begin
                        state_reg <= ST_BERS;
                        timer_reg <= 64'(BLK_ERS_CYC - 1);
                     end
                     PMM_OP_CHIP_ERASE: begin
                        state_reg <= ST_CERS;
                        timer_reg <= 64'(CHIP_ERS_CYC - 1);
                     end
                     default: begin
                        done <= 1'b1;
                     end
                  endcase
               end
            end
            ST_PROG: begin
               if (timer_done) begin
                  state_reg <= ST_IDLE;
                  done      <= 1'b1;
               end else begin
                  timer_reg <= timer_reg - 64'h1;
               end
            end
            ST_BERS, ST_CERS: begin
               if (!sweep_done) begin
                  sweep_reg <= sweep_reg + 17'h1;
               end
               if (!timer_done) begin
                  timer_reg <= timer_reg - 64'h1;
               end
               // ends only after both the erase time and the byte sweep
               if (timer_done && sweep_done) begin
                  state_reg <= ST_IDLE;
                  done      <= 1'b1;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
         if (cmd_valid && write_cmd && state_reg != ST_IDLE) begin
            cmd_refused <= 1'b1;
         end
      end
   end

   // array writes; the caller must not be fetching from the block being changed
   always_ff @(posedge mclk) begin
      if (state_reg == ST_PROG && timer_done) begin
         flash_mem[op_addr_reg] <= op_data_reg;
      end else if (state_reg == ST_CERS && !sweep_done) begin
         flash_mem[sweep_reg[15:0]] <= ERASED_BYTE;
      end else if (state_reg == ST_BERS && !sweep_done && block_of(sweep_reg[15:0]) == op_block_reg) begin
         flash_mem[sweep_reg[15:0]] <= ERASED_BYTE;
      end
   end

   // boot status and boot vector, erased together
   always_ff @(posedge mclk) begin
      if (state_reg == ST_IDLE && cmd_valid) begin
         case (cmd.op)
            PMM_OP_SET_STATUS: begin
               boot_status_reg <= cmd.wdata;
            end
            PMM_OP_SET_VECTOR: begin
               boot_vector_reg <= cmd.wdata;
            end
            PMM_OP_CLEAR_BOOT: begin
               boot_status_reg <= ERASED_BYTE;
               boot_vector_reg <= ERASED_BYTE;
            end
            PMM_OP_CHIP_ERASE: begin
               boot_status_reg <= boot_status_reg;
            end
            default: begin
               boot_vector_reg <= boot_vector_reg;
            end
         endcase
      end
   end

   // start address is taken at the first edge after reset release, not under reset
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         start_pend_reg <= 1'b1;
         start_valid    <= 1'b0;
         start_addr     <= RESET_START;
      end else if (start_pend_reg) begin
         start_pend_reg <= 1'b0;
         start_valid    <= 1'b1;
         if (boot_status_reg == STATUS_ZERO) begin
            start_addr <= RESET_START;
         end else begin
            start_addr <= {boot_vector_reg, START_LOW_BYTE};
         end
      end
   end
endmodule
`default_nettype wire

// *** dv/pmm_chk.sv ***
// Purpose: port assertions for the program-memory map
// Assumes: one clock, reset disables every check
// Notes:   sees top-level ports only
`timescale 1ns/1ps
`default_nettype none
module pmm_chk
   import pmm_pkg::*;
(
   input wire logic                   mclk,
   input wire logic                   rst,
   input wire pmm_pkg::pmm_fetch_type fetch,
   input wire logic                   fetch_valid,
   input wire logic [7:0]             fetch_data,
   input wire logic                   fetch_from_rom,
   input wire logic                   external_fetch_select_n,
   input wire logic                   ext_rd,
   input wire logic [7:0]             ext_data,
   input wire logic                   boot_rom_off,
   input wire logic                   boot_rom_enabled,
   input wire logic [15:0]            iap_entry,
   input wire logic                   cmd_valid,
   input wire pmm_pkg::pmm_cmd_type   cmd,
   input wire logic                   cmd_refused,
   input wire logic                   busy,
   input wire logic                   start_valid,
   input wire logic [15:0]            start_addr
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   ext_strobe_a: assert property (ext_rd == (fetch.req && !external_fetch_select_n))
      else $error("ext strobe wrong");
   ext_byte_a: assert property (fetch.req && !external_fetch_select_n |=> fetch_data == $past(ext_data) && !fetch_from_rom)
      else $error("ext byte wrong");
   fetch_ack_a: assert property (fetch.req |=> fetch_valid)
      else $error("fetch not answered");
   rom_hit_a: assert property (fetch.req && external_fetch_select_n && boot_rom_enabled && fetch.addr >= BOOT_ROM_BASE |=> fetch_from_rom)
      else $error("overlay missed");
   rom_miss_a: assert property (fetch.req && (fetch.addr < BOOT_ROM_BASE || !boot_rom_enabled) |=> !fetch_from_rom)
      else $error("overlay hit outside");
   off_wins_a: assert property (boot_rom_off |=> !boot_rom_enabled)
      else $error("overlay still on");
   refuse_cmd_a: assert property (cmd_valid && busy && cmd.op != PMM_OP_READ |=> cmd_refused)
      else $error("busy command not refused");
   entry_fixed_a: assert property (iap_entry == IAP_ENTRY_ADDR)
      else $error("entry moved");
   start_low_a: assert property (start_valid |-> start_addr[7:0] == START_LOW_BYTE)
      else $error("start low byte");
endmodule
bind pmm_flash_map pmm_chk chk (.mclk(mclk), .rst(rst), .fetch(fetch), .fetch_valid(fetch_valid),
   .fetch_data(fetch_data), .fetch_from_rom(fetch_from_rom), .external_fetch_select_n(external_fetch_select_n),
   .ext_rd(ext_rd), .ext_data(ext_data), .boot_rom_off(boot_rom_off), .boot_rom_enabled(boot_rom_enabled),
   .iap_entry(iap_entry), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_refused(cmd_refused), .busy(busy),
   .start_valid(start_valid), .start_addr(start_addr));
`default_nettype wire

// *** dv/pmm_ext_mem.sv ***
// Purpose: external program memory model
// Assumes: answers within the strobe cycle
// Notes:   byte is a fixed mix of the address
`timescale 1ns/1ps
`default_nettype none
module pmm_ext_mem (
   input  wire logic        mclk,
   input  wire logic        ext_rd,
   input  wire logic [15:0] ext_addr,
   output logic [7:0]       ext_data
);
   logic [7:0] last_reg = 8'h00;
   always_ff @(posedge mclk) if (ext_rd) last_reg <= ext_data;
   // released bus shows the inverse, so a stale capture never matches
   always_comb ext_data = ext_rd ? (ext_addr[15:8] ^ ext_addr[7:0] ^ 8'hA5) : ~last_reg;
endmodule
`default_nettype wire

// *** dv/pmm_flash_map_test.sv ***
// Purpose: self-checking bench for the program-memory map
// Assumes: short program and erase counts
// Notes:   the chip erase sweep dominates run time
`timescale 1ns/1ps
`default_nettype none
module pmm_flash_map_test;
   import pmm_pkg::*;
   logic mclk, rst, fetch_valid, fetch_from_rom, external_fetch_select_n, ext_rd, boot_rom_off, boot_rom_on;
   logic boot_rom_enabled, rom_load, cmd_valid, cmd_refused, busy, done, start_valid;
   logic [7:0] fetch_data, ext_data, rom_load_data, rd_data;
   logic [9:0] rom_load_addr;
   logic [15:0] ext_addr, iap_entry, start_addr;
   pmm_fetch_type fetch;
   pmm_cmd_type cmd;
   int num_errors = 0;
   int n_tests = 0;
   localparam int TB_PROG_CYC = 8;
   pmm_flash_map #(.PROG_CYC(TB_PROG_CYC), .BLK_ERS_CYC(4), .CHIP_ERS_CYC(4)) dut (.mclk(mclk), .rst(rst), .fetch(fetch),
      .fetch_valid(fetch_valid), .fetch_data(fetch_data), .fetch_from_rom(fetch_from_rom), .ext_rd(ext_rd),
      .external_fetch_select_n(external_fetch_select_n), .ext_addr(ext_addr), .ext_data(ext_data),
      .boot_rom_off(boot_rom_off), .boot_rom_on(boot_rom_on), .boot_rom_enabled(boot_rom_enabled),
      .rom_load(rom_load), .rom_load_addr(rom_load_addr), .rom_load_data(rom_load_data), .iap_entry(iap_entry),
      .cmd_valid(cmd_valid), .cmd(cmd), .cmd_refused(cmd_refused), .busy(busy), .done(done), .rd_data(rd_data),
      .start_addr(start_addr), .start_valid(start_valid));
   pmm_ext_mem mem (.mclk(mclk), .ext_rd(ext_rd), .ext_addr(ext_addr), .ext_data(ext_data));
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic issue(input pmm_op_type o, input logic [15:0] a, input logic [7:0] d);
      @(negedge mclk);
      cmd_valid = 1'b1;
      cmd = '{o, a, d};
      @(negedge mclk);
      cmd_valid = 1'b0;
   endtask
   task automatic wait_done(output int i);
      i = 0;
      while (done !== 1'b1 && i < 70000) begin
         @(negedge mclk);
         i++;
      end
      check("done", done, 1'b1);
   endtask
   task automatic op(input pmm_op_type o, input logic [15:0] a, input logic [7:0] d);
      int i;
      issue(o, a, d);
      wait_done(i);
   endtask
   task automatic fetch_at(input logic [15:0] a);
      @(negedge mclk);
      fetch = '{1'b1, a};
      @(negedge mclk);
      fetch.req = 1'b0;
      check("fetch_valid", fetch_valid, 1'b1);
   endtask
   task automatic do_reset(input int n);
      rst = 1'b1;
      repeat (n) @(negedge mclk);
      rst = 1'b0;
      @(negedge mclk);
      check("start_valid", start_valid, 1'b1);
   endtask
   task automatic test_map();
      logic [15:0] a [7] = '{16'h1FFF, 16'h2000, 16'h3FFF, 16'h4000, 16'hBFFF, 16'hC000, 16'hFBFF};
      for (int i = 0; i < 7; i++) op(PMM_OP_PROGRAM, a[i], 8'h10 + 8'(i));
      op(PMM_OP_BLOCK_ERASE, 16'h2000, 8'h00);
      for (int i = 0; i < 7; i++) begin
         op(PMM_OP_READ, a[i], 8'h00);
         check("rd_data", rd_data, (i == 1 || i == 2) ? ERASED_BYTE : 8'h10 + 8'(i));
      end
      fetch_at(16'hFBFF);
      check("fetch_data", fetch_data, 8'h16);
      $display("test_map finished");
   endtask
   task automatic test_busy();
      int i;
      issue(PMM_OP_PROGRAM, 16'h0100, 8'h3C); // stays outside the running block
      check("busy", busy, 1'b1);
      @(negedge mclk);
      cmd_valid = 1'b1;
      cmd = '{PMM_OP_CHIP_ERASE, 16'h0000, 8'h00};
      @(negedge mclk);
      cmd_valid = 1'b0;
      check("cmd_refused", cmd_refused, 1'b1);
      wait_done(i);
      // count starts two edges after the taking edge
      check("prog_time", 16'(i), 16'(TB_PROG_CYC - 2));
      check("busy", busy, 1'b0);
      op(PMM_OP_READ, 16'h0100, 8'h00);
      check("rd_data", rd_data, 8'h3C);
      $display("test_busy finished");
   endtask
   task automatic test_chip();
      int i;
      logic [15:0] a [4] = '{16'h0100, 16'h1FFF, 16'h4000, 16'hFBFF};
      issue(PMM_OP_CHIP_ERASE, 16'h0000, 8'h00);
      check("busy", busy, 1'b1);
      wait_done(i);
      for (int k = 0; k < 4; k++) begin
         op(PMM_OP_READ, a[k], 8'h00);
         check("rd_data", rd_data, ERASED_BYTE);
      end
      $display("test_chip finished");
   endtask
   task automatic test_rom();
      check("iap_entry", iap_entry, IAP_ENTRY_ADDR);
      op(PMM_OP_PROGRAM, BOOT_ROM_BASE, 8'h5A);
      @(negedge mclk);
      rom_load = 1'b1;
      rom_load_data = 8'hC3;
      @(negedge mclk);
      rom_load = 1'b0;
      fetch_at(BOOT_ROM_BASE);
      check("fetch_data", fetch_data, 8'hC3);
      check("fetch_from_rom", fetch_from_rom, 1'b1);
      boot_rom_off = 1'b1;
      boot_rom_on = 1'b1;
      @(negedge mclk);
      boot_rom_off = 1'b0;
      boot_rom_on = 1'b0;
      check("boot_rom_enabled", boot_rom_enabled, 1'b0);
      fetch_at(BOOT_ROM_BASE);
      check("fetch_data", fetch_data, 8'h5A);
      boot_rom_on = 1'b1;
      @(negedge mclk);
      boot_rom_on = 1'b0;
      check("boot_rom_enabled", boot_rom_enabled, 1'b1);
      $display("test_rom finished");
   endtask
   task automatic test_ext();
      external_fetch_select_n = 1'b0;
      fetch_at(BOOT_ROM_BASE);
      check("fetch_data", fetch_data, 8'h59);
      fetch_at(16'h1234);
      check("fetch_data", fetch_data, 8'h83);
      external_fetch_select_n = 1'b1;
      $display("test_ext finished");
   endtask
   task automatic test_boot();
      op(PMM_OP_SET_STATUS, 16'h0000, STATUS_ZERO);
      do_reset(2);
      check("start_addr", start_addr, RESET_START);
      op(PMM_OP_SET_STATUS, 16'h0000, 8'h01);
      op(PMM_OP_SET_VECTOR, 16'h0000, 8'h3A);
      do_reset(2);
      check("start_addr", start_addr, 16'h3A00);
      op(PMM_OP_CLEAR_BOOT, 16'h0000, 8'h00);
      do_reset(2);
      check("start_addr", start_addr, 16'hFF00);
      $display("test_boot finished");
   endtask
   initial begin
      rst = 1'b1;
      fetch = '0;
      cmd = '0;
      cmd_valid = 1'b0;
      external_fetch_select_n = 1'b1;
      boot_rom_off = 1'b0;
      boot_rom_on = 1'b0;
      rom_load = 1'b0;
      rom_load_addr = 10'h000;
      rom_load_data = 8'h00;
      do_reset(8);
      check("boot_rom_enabled", boot_rom_enabled, 1'b1);
      test_map();
      test_busy();
      test_chip();
      test_rom();
      test_ext();
      test_boot();
      tally_and_finish();
   end
   initial begin
      // chip erase sweep of 65536 cycles dominates the run
      #(40 * 90000);
      num_errors++;
      tally_and_finish();
   end
endmodule
`default_nettype wire
